// ==== common/irq_agg_pkg.sv ====
// Overview of operation
// R1 - fourteen core interrupt sources in total
// R2 - two shared pairs leave twelve pending
// R3 - reset source also taken at power-up; the code takes it only when POWER_UP_CONTEXT_RESET is set
// R4 - route one to nine sources onto line two
// R5 - core mask enables core-side sources
// R6 - core raw and masked status registers
// R7 - one to five sources drive host pin
// R8 - host mask enables host-side sources
// R9 - host raw and masked status readable
// R10 - crypto and host bus events accepted
// R11 - line two edge or level; pin types fixed
// R12 - masked equals raw and mask; any asserts
// R13 - masks reset to all disabled
package irq_agg_pkg;
    localparam int CORE_SRCS = 9;
    localparam int HOST_SRCS = 5;
    localparam int VEC_COUNT = 12;
    // register offsets
    localparam logic [3:0] OFS_CORE_MASK   = 4'h0;
    localparam logic [3:0] OFS_CORE_RAW    = 4'h1;
    localparam logic [3:0] OFS_CORE_MSK_ST = 4'h2;
    localparam logic [3:0] OFS_HOST_MASK   = 4'h3;
    localparam logic [3:0] OFS_HOST_RAW    = 4'h4;
    localparam logic [3:0] OFS_HOST_MSK_ST = 4'h5;
    localparam logic [3:0] OFS_PENDING     = 4'h6;
    localparam logic [3:0] OFS_CONFIG      = 4'h7;
    localparam logic [3:0] OFS_IRQ_STAT    = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK    = 4'h9;
    // reset values
    localparam logic [8:0] CORE_MASK_RST = 9'h000;
    localparam logic [4:0] HOST_MASK_RST = 5'h00;
    localparam logic [1:0] CONFIG_RST    = 2'h0;
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
    // pending vector bit positions
    localparam int VB_RESET = 0;
    localparam int VB_PWD   = 1;
    localparam int VB_S0TX  = 2;
    localparam int VB_S0RX  = 3;
    localparam int VB_BXFER = 4;
    localparam int VB_S1TX  = 5;
    localparam int VB_S1RX  = 6;
    localparam int VB_TIMER = 7;
    localparam int VB_LINE2 = 8;
    localparam int VB_LVL1  = 9;
    localparam int VB_LVL0  = 10;
    localparam int VB_EDGE  = 11;
    // config bits
    localparam int CFG_LINE2_EDGE = 0;
    localparam int CFG_S1_PINS    = 1;
    // internal sources travelling together
    typedef struct packed {
        logic power_down;
        logic s0_tx;
        logic s0_rx;
        logic bxfer;
        logic s1_tx;
        logic s1_rx;
        logic timer;
    } core_src_type;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;
endpackage

// ==== core/irq_agg_merge.sv ====
// one sub-controller: mask, raw and masked status, merged request
module irq_agg_merge #(
    parameter int N = 9
) (
    // sources and mask
    input  wire logic [N-1:0] raw,
    input  wire logic [N-1:0] mask,
    // results
    output logic [N-1:0] masked,
    output logic         any
);
    // masked status and or-merge
    assign masked = raw & mask; // see R12
    assign any    = |masked;    // see R12
endmodule

// ==== core/irq_agg_edge.sv ====
// rising edge detector producing a one-cycle pulse
module irq_agg_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // level in, pulse out
    input  wire logic lvl,
    output logic      pulse
);
    logic prev_r;
    // remember last level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_r <= 1'b0;
        else
            prev_r <= lvl;
    end
    assign pulse = lvl & ~prev_r;
endmodule

// ==== core/dual_interrupt_aggregator.sv ====
// core interrupt set with two added sub-controllers
module dual_interrupt_aggregator (
    // clock and reset
    input  wire logic                        MCLK,
    input  wire logic                        RST,
    // power-up context reset and power-up strobe
    input  wire logic                        POWER_UP_CONTEXT_RESET,
    input  wire logic                        POWER_UP_EVENT,
    // internal core sources
    input  wire irq_agg_pkg::core_src_type   CORE_SRC,
    // added sources for the sub-controllers
    input  wire logic [irq_agg_pkg::CORE_SRCS-1:0] CORE_SIDE_EVENTS,
    input  wire logic [irq_agg_pkg::HOST_SRCS-1:0] HOST_SIDE_EVENTS,
    // external request pins, active low
    input  wire logic                        EXT_REQUEST_LINE_TWO_N,
    input  wire logic                        LEVEL_REQUEST_ZERO_N,
    input  wire logic                        LEVEL_REQUEST_ONE_N,
    input  wire logic                        EDGE_REQUEST_PIN_N,
    input  wire logic                        EXT_REQUEST_ZERO_N,
    input  wire logic                        EXT_REQUEST_ONE_N,
    // pending acknowledge from core, one bit per vector
    input  wire logic [irq_agg_pkg::VEC_COUNT-1:0] VEC_ACK,
    // register port
    input  wire logic [3:0]                  ADDR,
    input  wire logic [15:0]                 WDATA,
    input  wire logic                        WR,
    input  wire logic                        RD,
    output logic [15:0]                      RDATA,
    // outputs
    output logic [irq_agg_pkg::VEC_COUNT-1:0] PENDING,
    output logic                             HOST_INTERRUPT_OUTPUT_N,
    output logic                             IRQ
);
    logic [8:0]  core_side_source_mask_r;
    logic [4:0]  host_side_source_mask_r;
    logic [1:0]  config_r;
    logic [11:0] pend_r;
    logic [11:0] pend_nxt;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_stat_nxt;
    logic [2:0]  irq_mask_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        host_out_r;
    logic [8:0]  core_side_raw_status;
    logic [8:0]  core_side_masked_status;
    logic [4:0]  host_side_raw_status;
    logic [4:0]  host_side_masked_status;
    logic        core_any;
    logic        host_any;
    logic        line2_lvl;
    logic        line2_edge;
    logic        line2_req;
    logic        edge_pin_pulse;
    logic        s1_tx_shared;
    logic        s1_rx_shared;
    logic [11:0] vec_set;
    logic [2:0]  irq_events;
    logic        host_prev_r;
    logic        core_prev_r;

    // register port strobes
    wire wr_core_mask = WR && (ADDR == irq_agg_pkg::OFS_CORE_MASK);
    wire wr_host_mask = WR && (ADDR == irq_agg_pkg::OFS_HOST_MASK);
    wire wr_config    = WR && (ADDR == irq_agg_pkg::OFS_CONFIG);
    wire wr_irq_mask  = WR && (ADDR == irq_agg_pkg::OFS_IRQ_MASK);
    wire rd_irq_stat  = RD && (ADDR == irq_agg_pkg::OFS_IRQ_STAT);

    // sub-controller raw inputs from crypto and host bus events
    assign core_side_raw_status = CORE_SIDE_EVENTS; // see R10
    assign host_side_raw_status = HOST_SIDE_EVENTS; // see R10

    // core-side merge onto line two
    irq_agg_merge #(
        .N (irq_agg_pkg::CORE_SRCS)
    ) u_core_merge (
        .raw    (core_side_raw_status),
        .mask   (core_side_source_mask_r), // see R5
        .masked (core_side_masked_status),
        .any    (core_any)                 // see R4
    );

    // host-side merge onto host pin
    irq_agg_merge #(
        .N (irq_agg_pkg::HOST_SRCS)
    ) u_host_merge (
        .raw    (host_side_raw_status),
        .mask   (host_side_source_mask_r), // see R8
        .masked (host_side_masked_status),
        .any    (host_any)                 // see R7
    );

    // line two request: pin or aggregated sub-controller
    assign line2_lvl = ~EXT_REQUEST_LINE_TWO_N | core_any; // see R4

    irq_agg_edge u_line2_edge (
        .clk   (MCLK),
        .rst   (RST),
        .lvl   (line2_lvl),
        .pulse (line2_edge)
    );

    irq_agg_edge u_edge_pin (
        .clk   (MCLK),
        .rst   (RST),
        .lvl   (~EDGE_REQUEST_PIN_N),
        .pulse (edge_pin_pulse)
    );

    // line two sensitivity selectable
    assign line2_req = config_r[irq_agg_pkg::CFG_LINE2_EDGE] ? line2_edge
                                                              : line2_lvl; // see R11

    // serial port one vectors shared with request pins one and zero
    assign s1_tx_shared = config_r[irq_agg_pkg::CFG_S1_PINS] ? ~EXT_REQUEST_ONE_N
                                                              : CORE_SRC.s1_tx; // see R2
    assign s1_rx_shared = config_r[irq_agg_pkg::CFG_S1_PINS] ? ~EXT_REQUEST_ZERO_N
                                                              : CORE_SRC.s1_rx; // see R2

    // fourteen sources folded onto twelve vectors
    assign vec_set[irq_agg_pkg::VB_RESET] = POWER_UP_EVENT && POWER_UP_CONTEXT_RESET; // see R3
    assign vec_set[irq_agg_pkg::VB_PWD]   = CORE_SRC.power_down; // see R1
    assign vec_set[irq_agg_pkg::VB_S0TX]  = CORE_SRC.s0_tx;
    assign vec_set[irq_agg_pkg::VB_S0RX]  = CORE_SRC.s0_rx;
    assign vec_set[irq_agg_pkg::VB_BXFER] = CORE_SRC.bxfer;
    assign vec_set[irq_agg_pkg::VB_S1TX]  = s1_tx_shared;
    assign vec_set[irq_agg_pkg::VB_S1RX]  = s1_rx_shared;
    assign vec_set[irq_agg_pkg::VB_TIMER] = CORE_SRC.timer;
    assign vec_set[irq_agg_pkg::VB_LINE2] = line2_req;
    assign vec_set[irq_agg_pkg::VB_LVL1]  = ~LEVEL_REQUEST_ONE_N;  // see R11
    assign vec_set[irq_agg_pkg::VB_LVL0]  = ~LEVEL_REQUEST_ZERO_N; // see R11
    assign vec_set[irq_agg_pkg::VB_EDGE]  = edge_pin_pulse;        // see R11

    // pending latches: set wins over acknowledge
    assign pend_nxt = vec_set | (pend_r & ~VEC_ACK); // see R1

    // sticky event status: rising of core and host outputs, power-up reset
    assign irq_events = {vec_set[irq_agg_pkg::VB_RESET],
                         host_any & ~host_prev_r,
                         core_any & ~core_prev_r};
    assign irq_stat_nxt = irq_events | (rd_irq_stat ? 3'h0 : irq_stat_r);

    // read mux
    always_comb
    begin
        rdata_nxt = 16'h0000;
        case (ADDR)
            irq_agg_pkg::OFS_CORE_MASK:   rdata_nxt = {7'h00, core_side_source_mask_r};
            irq_agg_pkg::OFS_CORE_RAW:    rdata_nxt = {7'h00, core_side_raw_status}; // see R6
            irq_agg_pkg::OFS_CORE_MSK_ST: rdata_nxt = {7'h00, core_side_masked_status}; // see R6
            irq_agg_pkg::OFS_HOST_MASK:   rdata_nxt = {11'h000, host_side_source_mask_r};
            irq_agg_pkg::OFS_HOST_RAW:    rdata_nxt = {11'h000, host_side_raw_status}; // see R9
            irq_agg_pkg::OFS_HOST_MSK_ST: rdata_nxt = {11'h000, host_side_masked_status}; // see R9
            irq_agg_pkg::OFS_PENDING:     rdata_nxt = {4'h0, pend_r};
            irq_agg_pkg::OFS_CONFIG:      rdata_nxt = {14'h0000, config_r};
            irq_agg_pkg::OFS_IRQ_STAT:    rdata_nxt = {13'h0000, irq_stat_r};
            irq_agg_pkg::OFS_IRQ_MASK:    rdata_nxt = {13'h0000, irq_mask_r};
            default:                      rdata_nxt = 16'h0000;
        endcase
    end

    // writable registers
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            core_side_source_mask_r <= irq_agg_pkg::CORE_MASK_RST; // see R13
            host_side_source_mask_r <= irq_agg_pkg::HOST_MASK_RST; // see R13
            config_r                <= irq_agg_pkg::CONFIG_RST;
            irq_mask_r              <= irq_agg_pkg::IRQ_MASK_RST;
        end
        else
        begin
            if (wr_core_mask)
                core_side_source_mask_r <= WDATA[8:0];
            if (wr_host_mask)
                host_side_source_mask_r <= WDATA[4:0];
            if (wr_config)
                config_r <= WDATA[1:0];
            if (wr_irq_mask)
                irq_mask_r <= WDATA[2:0];
        end
    end

    // status, pending, read data and host pin
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            pend_r      <= 12'h000;
            irq_stat_r  <= 3'h0;
            rdata_r     <= 16'h0000;
            host_out_r  <= 1'b0;
            host_prev_r <= 1'b0;
            core_prev_r <= 1'b0;
        end
        else
        begin
            pend_r      <= pend_nxt;
            irq_stat_r  <= irq_stat_nxt;
            rdata_r     <= RD ? rdata_nxt : 16'h0000;
            host_out_r  <= host_any; // see R7
            host_prev_r <= host_any;
            core_prev_r <= core_any;
        end
    end

    // outputs
    assign PENDING                 = pend_r;
    assign RDATA                   = rdata_r;
    assign HOST_INTERRUPT_OUTPUT_N = ~host_out_r;
    assign IRQ                     = |(irq_stat_r & irq_mask_r);
endmodule

// ==== testbench/dual_interrupt_aggregator_sva.sv ====
module dual_interrupt_aggregator_sva (
    // clock and reset
    input wire logic                      MCLK,
    input wire logic                      RST,
    // watched inputs
    input wire logic                      POWER_UP_CONTEXT_RESET,
    input wire logic                      POWER_UP_EVENT,
    input wire irq_agg_pkg::core_src_type CORE_SRC,
    input wire logic [4:0]                HOST_SIDE_EVENTS,
    input wire logic                      LEVEL_REQUEST_ZERO_N,
    input wire logic                      EDGE_REQUEST_PIN_N,
    input wire logic [11:0]               VEC_ACK,
    input wire logic                      RD,
    // watched outputs
    input wire logic [15:0]               RDATA,
    input wire logic [11:0]               PENDING,
    input wire logic                      HOST_INTERRUPT_OUTPUT_N
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain for every property
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not idle");
    AST_HOST_OFF: assert property ($past(HOST_SIDE_EVENTS) == 5'h00 &&
        $past(HOST_SIDE_EVENTS, 2) == 5'h00 |-> HOST_INTERRUPT_OUTPUT_N)
        else $error("host pin low without source");
    AST_EDGE_SET: assert property ($fell(EDGE_REQUEST_PIN_N) |-> ##[1:2] PENDING[11])
        else $error("edge request not pending");
    AST_LVL_SET: assert property (!LEVEL_REQUEST_ZERO_N |-> ##[1:2] PENDING[10])
        else $error("level request not pending");
    AST_PEND_HOLD: assert property (PENDING[11] && !VEC_ACK[11] |=> PENDING[11])
        else $error("pending lost without ack");
    AST_TIMER_SET: assert property (CORE_SRC.timer |-> ##[1:2] PENDING[7])
        else $error("timer not pending");
    AST_ACK_CLR: assert property (PENDING[7] && VEC_ACK[7] && !CORE_SRC.timer &&
        !$past(CORE_SRC.timer) |=> !PENDING[7])
        else $error("ack did not clear timer");
    AST_PWR_SET: assert property (POWER_UP_EVENT && POWER_UP_CONTEXT_RESET
        |-> ##[1:2] PENDING[0])
        else $error("power-up reset not pending");
    AST_PWR_SKIP: assert property (POWER_UP_EVENT && !POWER_UP_CONTEXT_RESET
        && !PENDING[0] |=> !PENDING[0])
        else $error("reset taken with context bit clear");
    // main scenarios
    cover property (POWER_UP_EVENT && POWER_UP_CONTEXT_RESET);
    cover property ($fell(HOST_INTERRUPT_OUTPUT_N));
    cover property (PENDING[11] && VEC_ACK[11]);
endmodule
bind dual_interrupt_aggregator dual_interrupt_aggregator_sva dual_interrupt_aggregator_sva_i (
    .MCLK(MCLK), .RST(RST), .POWER_UP_CONTEXT_RESET(POWER_UP_CONTEXT_RESET),
    .POWER_UP_EVENT(POWER_UP_EVENT), .CORE_SRC(CORE_SRC), .HOST_SIDE_EVENTS(HOST_SIDE_EVENTS),
    .LEVEL_REQUEST_ZERO_N(LEVEL_REQUEST_ZERO_N), .EDGE_REQUEST_PIN_N(EDGE_REQUEST_PIN_N),
    .VEC_ACK(VEC_ACK), .RD(RD), .RDATA(RDATA), .PENDING(PENDING),
    .HOST_INTERRUPT_OUTPUT_N(HOST_INTERRUPT_OUTPUT_N));

// ==== testbench/core_ack_model.sv ====
// core side: acknowledges each pending vector two cycles after seeing it
module core_ack_model (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // vectors
    input wire logic [11:0] pend,
    output logic     [11:0] ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] seen_r;
    // a one-cycle ack, never repeated while the previous one is out
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            seen_r <= 12'h000;
            ack    <= 12'h000;
        end
        else
        begin
            seen_r <= pend & ~ack;
            ack    <= seen_r & pend & ~ack;
        end
    end
endmodule

// ==== testbench/tb_dual_interrupt_aggregator.sv ====
module tb_dual_interrupt_aggregator;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     mclk, rst, power_up_context_reset, pue, l2_n, lvl0_n, lvl1_n, edge_n;
    logic                     ext0_n, ext1_n, wr, rd, irq, host_n;
    irq_agg_pkg::core_src_type csrc;
    logic [8:0]               cev;
    logic [4:0]               hev;
    logic [11:0]              ack, pend;
    logic [3:0]               addr;
    logic [15:0]              wdata, rdata, v;
    int                       err_count, n_compared;
    dual_interrupt_aggregator dual_interrupt_aggregator_i (.MCLK(mclk), .RST(rst),
        .POWER_UP_CONTEXT_RESET(power_up_context_reset), .POWER_UP_EVENT(pue), .CORE_SRC(csrc),
        .CORE_SIDE_EVENTS(cev), .HOST_SIDE_EVENTS(hev), .EXT_REQUEST_LINE_TWO_N(l2_n),
        .LEVEL_REQUEST_ZERO_N(lvl0_n), .LEVEL_REQUEST_ONE_N(lvl1_n),
        .EDGE_REQUEST_PIN_N(edge_n), .EXT_REQUEST_ZERO_N(ext0_n), .EXT_REQUEST_ONE_N(ext1_n),
        .VEC_ACK(ack), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PENDING(pend), .HOST_INTERRUPT_OUTPUT_N(host_n), .IRQ(irq));
    core_ack_model core_ack_model_i (.clk(mclk), .rst(rst), .pend(pend), .ack(ack));
    // 25 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task finish_test();
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register port cycles, one strobe cycle each
    task wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a; rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task rchk(input logic [3:0] a, input logic [15:0] exp);
        rreg(a, v);
        chk(v, exp);
    endtask
    // pending bit must show within two edges
    task wait_pend(input int b);
        logic hit;
        hit = 1'b0;
        repeat (3)
        begin
            #1 if (pend[b] === 1'b1) hit = 1'b1;
            @(posedge mclk);
        end
        chk(16'(hit), 16'h0001);
    endtask
    task t_reset();
        rchk(irq_agg_pkg::OFS_CORE_MASK, 16'h0000);
        rchk(irq_agg_pkg::OFS_HOST_MASK, 16'h0000);
        chk(16'({host_n, irq}), 16'h0002);
        rchk(4'hf, 16'h0000);
    endtask
    task t_vectors();
        for (int i = 0; i < 7; i++)
        begin
            @(posedge mclk) csrc <= irq_agg_pkg::core_src_type'(7'h01 << i);
            @(posedge mclk) csrc <= '0;
            wait_pend(7 - i);
        end
        @(posedge mclk) edge_n <= 1'b0;
        @(posedge mclk) edge_n <= 1'b1;
        wait_pend(irq_agg_pkg::VB_EDGE);
        @(posedge mclk) lvl0_n <= 1'b0;
        @(posedge mclk) lvl0_n <= 1'b1;
        wait_pend(irq_agg_pkg::VB_LVL0);
        @(posedge mclk) pue <= 1'b1;
        @(posedge mclk) pue <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(16'(pend[0]), 16'h0000);
        @(posedge mclk) begin pue <= 1'b1; power_up_context_reset <= 1'b1; end
        @(posedge mclk) pue <= 1'b0;
        wait_pend(irq_agg_pkg::VB_RESET);
    endtask
    task t_shared();
        wreg(irq_agg_pkg::OFS_CONFIG, 16'h0002);
        @(posedge mclk) ext1_n <= 1'b0;
        @(posedge mclk) ext1_n <= 1'b1;
        wait_pend(irq_agg_pkg::VB_S1TX);
        @(posedge mclk) ext0_n <= 1'b0;
        @(posedge mclk) ext0_n <= 1'b1;
        wait_pend(irq_agg_pkg::VB_S1RX);
        wreg(irq_agg_pkg::OFS_CONFIG, 16'h0000);
    endtask
    task t_core();
        @(posedge mclk) cev <= 9'h1a5;
        wreg(irq_agg_pkg::OFS_CORE_MASK, 16'h00f0);
        rchk(irq_agg_pkg::OFS_CORE_RAW, 16'h01a5);
        rchk(irq_agg_pkg::OFS_CORE_MSK_ST, 16'h00a0);
        wait_pend(irq_agg_pkg::VB_LINE2);
        wreg(irq_agg_pkg::OFS_CORE_MASK, 16'h01ff);
        rchk(irq_agg_pkg::OFS_CORE_MSK_ST, 16'h01a5);
        @(posedge mclk) cev <= 9'h000;
        wreg(irq_agg_pkg::OFS_CORE_MASK, 16'h0000);
    endtask
    task t_host();
        rchk(irq_agg_pkg::OFS_IRQ_STAT, 16'h0005);
        wreg(irq_agg_pkg::OFS_IRQ_MASK, 16'h0002);
        rchk(irq_agg_pkg::OFS_IRQ_MASK, 16'h0002);
        wreg(irq_agg_pkg::OFS_HOST_MASK, 16'h0004);
        @(posedge mclk) hev <= 5'h15;
        repeat (3) @(posedge mclk);
        #1 chk(16'({host_n, irq}), 16'h0001);
        rchk(irq_agg_pkg::OFS_HOST_RAW, 16'h0015);
        rchk(irq_agg_pkg::OFS_HOST_MSK_ST, 16'h0004);
        rchk(irq_agg_pkg::OFS_IRQ_STAT, 16'h0002);
        chk(16'(irq), 16'h0000);
        wreg(irq_agg_pkg::OFS_HOST_MASK, 16'h000a);
        repeat (3) @(posedge mclk);
        #1 chk(16'(host_n), 16'h0001);
    endtask
    // line two in edge mode pends once per edge; level pin one holds its vector
    task t_line2();
        wreg(irq_agg_pkg::OFS_CONFIG, 16'h0001);
        rchk(irq_agg_pkg::OFS_CONFIG, 16'h0001);
        @(posedge mclk) l2_n <= 1'b0;
        wait_pend(irq_agg_pkg::VB_LINE2);
        repeat (6) @(posedge mclk);
        #1 chk(16'(pend[irq_agg_pkg::VB_LINE2]), 16'h0000);
        @(posedge mclk) l2_n <= 1'b1;
        wreg(irq_agg_pkg::OFS_CONFIG, 16'h0000);
        @(posedge mclk) lvl1_n <= 1'b0;
        wait_pend(irq_agg_pkg::VB_LVL1);
        rchk(irq_agg_pkg::OFS_PENDING, 16'h0200);
        @(posedge mclk) lvl1_n <= 1'b1;
    endtask
    // reset in mid-run clears masks that were written
    task t_rerst();
        wreg(irq_agg_pkg::OFS_CORE_MASK, 16'h01ff);
        @(posedge mclk) rst <= 1'b1;
        @(posedge mclk) rst <= 1'b0;
        rchk(irq_agg_pkg::OFS_CORE_MASK, 16'h0000);
        rchk(irq_agg_pkg::OFS_HOST_MASK, 16'h0000);
        chk(16'({host_n, irq}), 16'h0002);
    endtask
    // stimulus
    initial
    begin
        err_count = 0; n_compared = 0;
        rst = 1'b1; power_up_context_reset = 1'b0; pue = 1'b0; l2_n = 1'b1; lvl0_n = 1'b1; lvl1_n = 1'b1;
        edge_n = 1'b1; ext0_n = 1'b1; ext1_n = 1'b1; wr = 1'b0; rd = 1'b0;
        csrc = '0; cev = 9'h000; hev = 5'h00; addr = 4'h0; wdata = 16'h0000;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_vectors();
        t_shared();
        t_core();
        t_host();
        t_line2();
        t_rerst();
        finish_test();
    end
    // hang guard
    initial
    begin
        #40000;
        err_count++;
        finish_test();
    end
endmodule
